// ===== design/stc_timer.sv
// Sixteen bit timer and event counter with AXI4-Lite register slave
// What this block does
// - 16-bit up-counter; reset keeps timer registers
// - Timer mode: count, match interrupt, clear, continue
// - Soft capture copies counter, bit self-clears
// - Low write inhibits compare; one cycle guard after
// - Control and match registers are write-only
// - Capture writes ignored outside pulse generator mode
// - Auto-capture copies counter on each source clock
// - Clock select picks one of three taps, except low speed forces coarse
// - Trigger edge starts; match clears and halts
// - Reverse-edge stop bit: opposite edge clears, stops
// - Trigger edges ignored while counting before match
// - Input filter rejects short pulses except at low speed
// - Event mode counts pin edges, clears on match
// - Window mode counts pin gated clock edges
module stc_timer #(
   parameter int CNT_WIDTH = 16   // Counter width
) (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // AXI4-Lite write address and data
   input  wire logic [7:0]                  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output      logic                        s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output      logic                        s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]                  s_axi_bresp,
   output      logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]                  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output      logic                        s_axi_arready,
   output      logic [31:0]                 s_axi_rdata,
   output      logic [1:0]                  s_axi_rresp,
   output      logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   // Pin and interrupt
   input  wire logic                        timer_pin,
   input  wire logic                        low_speed,
   output      logic                        match_interrupt
);
   import stc_pkg::*;

   // ****************************************
   // Registers
   // ****************************************
   logic [8:0]           counter_control_reg;  // Control, bit 8 auto capture
   logic [CNT_WIDTH-1:0] match_value_reg;      // Compare value
   logic [CNT_WIDTH-1:0] capture_value_reg;    // Capture value
   logic [CNT_WIDTH-1:0] auto_capture_reg;     // Auto capture value
   logic                 trigger_edge_select;  // Zero rising, one falling
   logic [CNT_WIDTH-1:0] count;                // Up-counter
   stc_state_type        state;                // Run state
   logic                 cmp_hold;             // Compare inhibited after low write
   logic                 cmp_guard;            // One cycle guard after high write
   logic [STC_DIV_BITS-1:0] prescale;          // Free running divider
   logic [STC_DIV_BITS-1:0] prescale_q;        // Previous divider value
   logic                 pin_flt;              // Filtered pin level
   logic                 pin_flt_q;            // Previous filtered level
   logic [STC_FLT_BITS-1:0] flt_cnt;           // Filter stability count
   logic                 win_gate_q;           // Previous window gated clock
   // Bus state
   logic                 aw_seen;
   logic                 w_seen;
   logic [7:0]           aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;

   // ****************************************
   // Field decode
   // ****************************************
   wire stc_mode_type mode      = stc_mode_type'(counter_control_reg[STC_MODE_LSB +: 3]);
   wire logic [1:0]   clk_sel   = counter_control_reg[STC_CLK_LSB +: 2];
   wire logic [1:0]   start_fld = counter_control_reg[STC_START_LSB +: 2];
   wire logic         bit6      = counter_control_reg[STC_BIT6];
   wire logic         acap_en   = counter_control_reg[STC_ACAP_BIT];

   // Tap bit of the divider, used as a rising edge detector
   function automatic logic tap_bit(input logic [STC_DIV_BITS-1:0] p, input logic [1:0] s,
                                    input logic slow);
      // Only the coarse tap is usable at low speed
      if (slow)
         tap_bit = p[STC_DIV_COARSE];
      else if (s == STC_TAP_FINE)
         tap_bit = p[STC_DIV_FINE];
      else if (s == STC_TAP_MID)
         tap_bit = p[STC_DIV_MID];
      else
         tap_bit = p[STC_DIV_COARSE];
   endfunction : tap_bit

   wire logic int_tick = tap_bit(prescale, clk_sel, low_speed) &
                         ~tap_bit(prescale_q, clk_sel, low_speed);
   wire logic pin_rise = pin_flt & ~pin_flt_q;
   wire logic pin_fall = ~pin_flt & pin_flt_q;
   wire logic trig_edge = trigger_edge_select ? pin_fall : pin_rise;
   wire logic rev_edge  = trigger_edge_select ? pin_rise : pin_fall;
   // window pulse anded with internal clock, polarity selectable
   wire logic win_gate  = (pin_flt ^ trigger_edge_select) &
                          tap_bit(prescale, clk_sel, low_speed);
   wire logic win_tick  = win_gate & ~win_gate_q;

   // Source clock per mode
   wire logic src_tick = (mode == STC_MODE_EVENT)  ? trig_edge :
                         (mode == STC_MODE_WINDOW) ? win_tick : int_tick;
   wire logic running  = (state == STC_ST_RUN);
   wire logic cmp_ok   = ~cmp_hold & ~cmp_guard;
   // compare suppressed while held or guarded
   wire logic match    = running & src_tick & cmp_ok &
                         (count == match_value_reg);

   // ****************************************
   // Bus decode
   // ****************************************
   wire logic wr_go  = aw_seen & w_seen & ~s_axi_bvalid;
   wire logic wr_ctl = wr_go & (aw_addr == STC_ADDR_CONTROL);
   wire logic wr_mat = wr_go & (aw_addr == STC_ADDR_MATCH);
   wire logic wr_cap = wr_go & (aw_addr == STC_ADDR_CAPTURE);
   wire logic wr_ext = wr_go & (aw_addr == STC_ADDR_EXTCTL);
   wire logic wr_ok  = wr_ctl | wr_mat | wr_cap | wr_ext;
   wire logic mat_lo = wr_mat & w_strb[0];
   wire logic mat_hi = wr_mat & w_strb[1];
   wire logic soft_cap = running & bit6 &
                         (mode == STC_MODE_TIMER || mode == STC_MODE_EVENT ||
                          mode == STC_MODE_WINDOW);

   assign s_axi_awready = ~aw_seen;
   assign s_axi_wready  = ~w_seen;
   assign s_axi_arready = ~s_axi_rvalid;

   // ****************************************
   // Write channel capture and response
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         aw_seen      <= 1'b0;
         w_seen       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= STC_RESP_OKAY;
      end else begin
         // Address and data taken in either order
         if (s_axi_awvalid && !aw_seen) begin
            aw_seen <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_seen) begin
            w_seen <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? STC_RESP_OKAY : STC_RESP_SLVERR;
            aw_seen      <= 1'b0;
            w_seen       <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   // control and match read back as zero
   wire logic [31:0] rd_mux =
      (s_axi_araddr == STC_ADDR_CAPTURE) ? {16'h0000, capture_value_reg} :
      (s_axi_araddr == STC_ADDR_AUTOCAP) ? {16'h0000, auto_capture_reg} :
      (s_axi_araddr == STC_ADDR_STATUS)  ? {14'h0000, state, count} :
      (s_axi_araddr == STC_ADDR_EXTCTL)  ? {31'h0000_0000, trigger_edge_select} :
      32'h0000_0000;
   wire logic rd_ok = (s_axi_araddr == STC_ADDR_CAPTURE) || (s_axi_araddr == STC_ADDR_AUTOCAP) ||
                      (s_axi_araddr == STC_ADDR_STATUS)  || (s_axi_araddr == STC_ADDR_EXTCTL) ||
                      (s_axi_araddr == STC_ADDR_CONTROL) || (s_axi_araddr == STC_ADDR_MATCH);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= STC_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_ok ? STC_RESP_OKAY : STC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Prescaler and input filter
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prescale   <= '0;
         prescale_q <= '0;
         pin_flt    <= 1'b0;
         pin_flt_q  <= 1'b0;
         flt_cnt    <= '0;
         win_gate_q <= 1'b0;
      end else begin
         prescale   <= prescale + 1'b1;
         prescale_q <= prescale;
         pin_flt_q  <= pin_flt;
         win_gate_q <= win_gate;
         // level must hold past the reject width; filter off at low speed
         if (low_speed || timer_pin == pin_flt) begin
            flt_cnt <= '0;
            pin_flt <= low_speed ? timer_pin : pin_flt;
         end else if (flt_cnt == STC_FLT_BITS'(STC_FLT_REJECT)) begin
            pin_flt <= timer_pin;
            flt_cnt <= '0;
         end else begin
            flt_cnt <= flt_cnt + 1'b1;
         end
      end
   end

   // ****************************************
   // Control registers (timer registers keep value on reset)
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         counter_control_reg <= '0;
         trigger_edge_select <= 1'b0;
      end else begin
         if (wr_ctl)
            counter_control_reg <= w_data[8:0];
         else if (soft_cap && mode != STC_MODE_EXTTRG)
            counter_control_reg[STC_BIT6] <= 1'b0;
         if (wr_ext)
            trigger_edge_select <= w_data[0];
      end
   end

   // no reset on match, capture and auto capture registers
   always_ff @(posedge core_clk) begin
      if (mat_lo)
         match_value_reg[7:0] <= w_data[7:0];
      if (mat_hi)
         match_value_reg[CNT_WIDTH-1:8] <= w_data[CNT_WIDTH-1:8];
      // writes land only in pulse generator mode
      if (wr_cap && mode == STC_MODE_PPG)
         capture_value_reg <= w_data[CNT_WIDTH-1:0];
      else if (soft_cap && !wr_ctl)
         capture_value_reg <= count;
      if (acap_en && running && src_tick)
         auto_capture_reg <= count;
   end

   // ****************************************
   // Counter and run state
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state           <= STC_ST_IDLE;
         count           <= '0;
         cmp_hold        <= 1'b0;
         cmp_guard       <= 1'b0;
         match_interrupt <= 1'b0;
      end else begin
         // low write holds compare until high written, then guard
         if (mat_lo && !mat_hi)
            cmp_hold <= 1'b1;
         else if (mat_hi)
            cmp_hold <= 1'b0;
         cmp_guard <= mat_hi;
         match_interrupt <= match;
         case (state)
            STC_ST_IDLE: begin
               count <= '0;
               if (start_fld == STC_START_EXT && mode == STC_MODE_EXTTRG)
                  state <= STC_ST_WAIT;
               else if (start_fld != STC_START_STOP)
                  state <= STC_ST_RUN;
            end
            STC_ST_WAIT: begin
               if (start_fld == STC_START_STOP)
                  state <= STC_ST_IDLE;
               else if (trig_edge)
                  state <= STC_ST_RUN;
            end
            STC_ST_RUN: begin
               if (start_fld == STC_START_STOP) begin
                  state <= STC_ST_IDLE;
               // reverse edge clears and stops when enabled
               end else if (mode == STC_MODE_EXTTRG && bit6 && rev_edge) begin
                  count <= '0;
                  state <= STC_ST_WAIT;
               // clear on match; halt in trigger mode
               end else if (match) begin
                  count <= '0;
                  if (mode == STC_MODE_EXTTRG)
                     state <= STC_ST_WAIT;
               // trigger edges ignored here while counting
               end else if (src_tick) begin
                  count <= count + 1'b1;
               end
            end
            default: state <= STC_ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_match_pulse: assert property (@(posedge core_clk) disable iff (rst)
      match |=> match_interrupt ##1 !match_interrupt)
      else $error("match pulse wrong");
   a_match_clear: assert property (@(posedge core_clk) disable iff (rst)
      match && start_fld != STC_START_STOP |=> count == '0)
      else $error("count not cleared on match");
   a_hold_block: assert property (@(posedge core_clk) disable iff (rst)
      cmp_hold |-> !match)
      else $error("match while compare held");
   a_guard_cycle: assert property (@(posedge core_clk) disable iff (rst)
      mat_hi |=> !match)
      else $error("match during guard cycle");
   a_trig_halt: assert property (@(posedge core_clk) disable iff (rst)
      match && mode == STC_MODE_EXTTRG && start_fld != STC_START_STOP |=> state == STC_ST_WAIT)
      else $error("trigger mode did not halt");
   a_cap_block: assert property (@(posedge core_clk) disable iff (rst)
      wr_cap && mode != STC_MODE_PPG && !soft_cap |=> $stable(capture_value_reg))
      else $error("capture write accepted");
   a_soft_cap: assert property (@(posedge core_clk) disable iff (rst)
      soft_cap && !wr_ctl && mode != STC_MODE_EXTTRG |=>
         capture_value_reg == $past(count) && !bit6)
      else $error("soft capture wrong");
   a_rev_stop: assert property (@(posedge core_clk) disable iff (rst)
      running && mode == STC_MODE_EXTTRG && bit6 && rev_edge && start_fld != STC_START_STOP
      |=> count == '0 && state == STC_ST_WAIT)
      else $error("reverse edge did not stop");

endmodule : stc_timer

// ===== design/stc_pkg.sv
// Package of constants for the sixteen bit timer and event counter
package stc_pkg;

   // ****************************************
   // Register byte addresses (one word each)
   // ****************************************
   localparam logic [7:0] STC_ADDR_CONTROL = 8'h00;   // Control, write only
   localparam logic [7:0] STC_ADDR_MATCH   = 8'h04;   // Match value, write only
   localparam logic [7:0] STC_ADDR_CAPTURE = 8'h08;   // Capture value
   localparam logic [7:0] STC_ADDR_AUTOCAP = 8'h0C;   // Auto capture, read only
   localparam logic [7:0] STC_ADDR_STATUS  = 8'h10;   // Live counter and state
   localparam logic [7:0] STC_ADDR_EXTCTL  = 8'h14;   // Trigger edge select

   // ****************************************
   // Control register field positions
   // ****************************************
   localparam int STC_MODE_LSB  = 0;   // Mode field, three bits
   localparam int STC_CLK_LSB   = 2;   // Source clock select, two bits (low bit shares mode bit 2)
   localparam int STC_START_LSB = 4;   // Start control field, two bits
   localparam int STC_BIT6      = 6;   // Soft capture / reverse edge stop
   localparam int STC_TFF_BIT   = 7;   // Flip-flop initial value
   localparam int STC_ACAP_BIT  = 8;   // Auto capture enable

   // ****************************************
   // Operating modes
   // ****************************************
   typedef enum logic [2:0] {
      STC_MODE_TIMER  = 3'b000,
      STC_MODE_EXTTRG = 3'b001,
      STC_MODE_EVENT  = 3'b010,
      STC_MODE_WINDOW = 3'b011,
      STC_MODE_PWM    = 3'b100,
      STC_MODE_PPG    = 3'b101
   } stc_mode_type;

   // Start control encodings
   localparam logic [1:0] STC_START_STOP = 2'b00;
   localparam logic [1:0] STC_START_CMD  = 2'b01;
   localparam logic [1:0] STC_START_EXT  = 2'b10;

   // Source clock taps, coarse to fine
   localparam logic [1:0] STC_TAP_COARSE = 2'b00;
   localparam logic [1:0] STC_TAP_MID    = 2'b01;
   localparam logic [1:0] STC_TAP_FINE   = 2'b10;

   // ****************************************
   // Prescaler and filter timing
   // ****************************************
   localparam int STC_DIV_COARSE = 11;   // Divider stage, coarse tap
   localparam int STC_DIV_MID    = 7;    // Divider stage, middle tap
   localparam int STC_DIV_FINE   = 3;    // Divider stage, fine tap
   localparam int STC_DIV_BITS   = 12;   // Prescaler width
   localparam int STC_FLT_REJECT = 7;    // Pulses of this many fc or less are noise
   localparam int STC_FLT_ACCEPT = 24;   // Pulses of this many fc are detected
   localparam int STC_FLT_BITS   = 5;    // Filter counter width
   localparam int STC_GUARD_CYC  = 1;    // Match ignored for one machine cycle

   // AXI responses
   localparam logic [1:0] STC_RESP_OKAY   = 2'b00;
   localparam logic [1:0] STC_RESP_SLVERR = 2'b10;

   // Run state of the counter
   typedef enum logic [1:0] {
      STC_ST_IDLE = 2'b00,
      STC_ST_WAIT = 2'b01,
      STC_ST_RUN  = 2'b10
   } stc_state_type;

endpackage : stc_pkg

// ===== verification/stc_pin_source.sv
// External pulse and event source driving the timer input pin
module stc_pin_source (
   // Clock
   input  wire logic core_clk,
   // Pin
   output      logic timer_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Pin driver
   // ****************************************
   // Pin rests low so the first rising edge is clean
   initial timer_pin = 1'b0;

   // Whole-cycle levels; caller must start just after a rising edge
   // width and spacing
   task automatic drive(input logic lvl, input int cyc);
      timer_pin <= lvl;
      repeat (cyc) @(posedge core_clk);
   endtask : drive
endmodule : stc_pin_source

// ===== verification/stc_timer_test.sv
// Self-checking bench for the sixteen bit timer and event counter
module stc_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   import stc_pkg::*;

   // ****************************************
   // Signals and instances
   // ****************************************
   logic        core_clk = 1'b0, rst = 1'b1;               // Clock, reset
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;      // Addresses
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;             // Data
   logic [3:0]  s_axi_wstrb = '0;                          // Byte strobes
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, low_speed = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;                  // Responses
   logic        timer_pin, match_interrupt;                // Pin, interrupt
   int          errors = 0, n_compared = 0, irq_count = 0; // Tallies
   logic [31:0] d, c;                                      // Read scratch
   logic [1:0]  r, b;                                      // Read and write response scratch

   stc_timer uut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .timer_pin(timer_pin), .low_speed(low_speed),
      .match_interrupt(match_interrupt));
   stc_pin_source src (.core_clk(core_clk), .timer_pin(timer_pin));

   // 125 MHz clock
   always #4 core_clk = ~core_clk;
   // Interrupt pulses counted as they happen
   always @(posedge core_clk) if (match_interrupt === 1'b1) irq_count++;

   // ****************************************
   // Bus and compare tasks
   // ****************************************
   // Handshakes judged at the rising edge; each valid dropped at the edge it is taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      b = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
         rd = s_axi_rdata;
         rr = s_axi_rresp;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : axi_read

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   // Cycles up to the next interrupt, bounded
   task automatic wait_irq(output int n);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (match_interrupt !== 1'b1 && n < 5000);
      if (match_interrupt !== 1'b1) errors++;
   endtask : wait_irq

   task automatic stop_test();
      $display("errors %0d, compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   // ****************************************
   // Scenarios
   // ****************************************
   // Edge counting, glitch rejection, clear on match
   task automatic event_case();
      int n0;
      axi_write(STC_ADDR_MATCH, 32'h0000_0002, 4'b0011);
      axi_write(STC_ADDR_EXTCTL, 32'h0000_0000, 4'b0001);
      // flip-flop initial bit always written zero
      axi_write(STC_ADDR_CONTROL, 32'h0000_0002, 4'b0001);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0012, 4'b0001);
      repeat (2) begin
         src.drive(1'b1, 30);
         src.drive(1'b0, 30);
      end
      axi_read(STC_ADDR_STATUS, d, r);
      check({16'h0000, d[15:0]}, 32'h0000_0002);
      src.drive(1'b1, 5);
      src.drive(1'b0, 30);
      axi_read(STC_ADDR_STATUS, d, r);
      check({16'h0000, d[15:0]}, 32'h0000_0002);
      n0 = irq_count;
      src.drive(1'b1, 30);
      src.drive(1'b0, 30);
      axi_read(STC_ADDR_STATUS, d, r);
      check(32'(irq_count - n0), 32'h0000_0001);
      check({16'h0000, d[15:0]}, 32'h0000_0000);
   endtask : event_case

   // Trigger edge starts, match clears and waits again
   task automatic trigger_case();
      int n0;
      axi_write(STC_ADDR_CONTROL, 32'h0000_0000, 4'b0001);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0009, 4'b0001);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0029, 4'b0001);
      axi_read(STC_ADDR_STATUS, d, r);
      check({30'h0, d[17:16]}, 32'h0000_0001);
      n0 = irq_count;
      src.drive(1'b1, 12);
      axi_read(STC_ADDR_STATUS, d, r);
      check({30'h0, d[17:16]}, 32'h0000_0002);
      src.drive(1'b0, 80);
      axi_read(STC_ADDR_STATUS, d, r);
      check(32'(irq_count - n0), 32'h0000_0001);
      check(d & 32'h0003_FFFF, 32'h0001_0000);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0049, 4'b0001);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0069, 4'b0001);
      n0 = irq_count;
      src.drive(1'b1, 12);
      src.drive(1'b0, 12);
      axi_read(STC_ADDR_STATUS, d, r);
      check(32'(irq_count - n0), 32'h0000_0000);
      check(d & 32'h0003_FFFF, 32'h0001_0000);
   endtask : trigger_case

   // Period, soft capture, capture write, low byte inhibit
   task automatic timer_case();
      int n, n0;
      axi_write(STC_ADDR_CONTROL, 32'h0000_0000, 4'b0001);
      axi_write(STC_ADDR_MATCH, 32'h0000_0003, 4'b0011);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0008, 4'b0001);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0018, 4'b0001);
      wait_irq(n);
      wait_irq(n);
      check(32'(n), 32'h0000_0040);
      axi_read(STC_ADDR_STATUS, d, r);
      check(d & 32'h0003_FFFF, 32'h0002_0000);
      // soft capture used in timer mode
      axi_write(STC_ADDR_CONTROL, 32'h0000_0058, 4'b0001);
      axi_read(STC_ADDR_CAPTURE, c, r);
      check(c & 32'hFFFF_FFFC, 32'h0000_0000);
      axi_write(STC_ADDR_CAPTURE, 32'h0000_BEEF, 4'b0011);
      axi_read(STC_ADDR_CAPTURE, d, r);
      check(d, c);
      wait_irq(n);
      axi_write(STC_ADDR_MATCH, 32'h0000_0001, 4'b0001);
      n0 = irq_count;
      repeat (100) @(posedge core_clk);
      check(32'(irq_count - n0), 32'h0000_0000);
      // stop before changing capture or clock setup
      axi_write(STC_ADDR_CONTROL, 32'h0000_0000, 4'b0001);
      axi_write(STC_ADDR_MATCH, 32'h0000_0003, 4'b0011);
      // auto capture read while running and enabled
      axi_write(STC_ADDR_CONTROL, 32'h0000_0118, 4'b0011);
      wait_irq(n);
      axi_read(STC_ADDR_AUTOCAP, d, r);
      check(d, 32'h0000_0003);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0000, 4'b0001);
      axi_write(STC_ADDR_MATCH, 32'h0000_0001, 4'b0011);
      low_speed <= 1'b1;
      axi_write(STC_ADDR_CONTROL, 32'h0000_0018, 4'b0001);
      n0 = irq_count;
      // Fine tap asked for, coarse tap forced: no two ticks in this span
      repeat (200) @(posedge core_clk);
      check(32'(irq_count - n0), 32'h0000_0000);
      low_speed <= 1'b0;
      axi_write(STC_ADDR_CONTROL, 32'h0000_0000, 4'b0001);
   endtask : timer_case

   // Window pulse gates the fine internal clock
   task automatic window_case();
      axi_write(STC_ADDR_MATCH, 32'h0000_0100, 4'b0011);
      axi_write(STC_ADDR_CONTROL, 32'h0000_000B, 4'b0001);
      axi_write(STC_ADDR_CONTROL, 32'h0000_001B, 4'b0001);
      // window far slower than the fine tap
      src.drive(1'b0, 100);
      axi_read(STC_ADDR_STATUS, d, r);
      check({16'h0000, d[15:0]}, 32'h0000_0000);
      src.drive(1'b1, 100);
      axi_read(STC_ADDR_STATUS, d, r);
      check({31'h0, d[15:0] == 16'h0000}, 32'h0000_0000);
      axi_write(STC_ADDR_CONTROL, 32'h0000_0000, 4'b0001);
   endtask : window_case

   // Write-only reads, unmapped address, capture kept over reset
   task automatic reg_case();
      axi_read(STC_ADDR_CONTROL, d, r);
      check({r, d}, {STC_RESP_OKAY, 32'h0000_0000});
      axi_read(8'h40, d, r);
      check({30'h0, r}, {30'h0, STC_RESP_SLVERR});
      axi_write(8'h40, 32'h0000_0000, 4'b1111);
      check({30'h0, b}, {30'h0, STC_RESP_SLVERR});
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      axi_read(STC_ADDR_CAPTURE, d, r);
      check(d, c);
   endtask : reg_case

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      event_case();
      trigger_case();
      timer_case();
      window_case();
      reg_case();
      stop_test();
   end

   // Whole run needs under two thousand cycles
   initial begin
      #200000;
      errors++;
      stop_test();
   end
endmodule : stc_timer_test
